// ==== include/gst_pkg.sv ====
// Shared constants and types for the gated sweep trigger control block.
// Assumes a 250 MHz reference clock and a 125 ns internal time base.
package gst_pkg;
    // Reference clock period in picoseconds.
    localparam int unsigned CLK_PERIOD_PS = 4000;
    // Internal time base period in nanoseconds.
    localparam int unsigned TICK_NS = 125;
    // Clock cycles per time base tick, rounded down but never below one.
    localparam int unsigned TICK_CYCLES = ((TICK_NS * 1000) / CLK_PERIOD_PS) < 1 ? 1 :
        ((TICK_NS * 1000) / CLK_PERIOD_PS);
    // Longest programmable delay or length, in seconds.
    localparam int unsigned MAX_TIME_S = 100;
    // Longest delay or length expressed in ticks (100 s / 125 ns).
    localparam longint unsigned MAX_TICKS = (64'(MAX_TIME_S) * 64'd1000000000) / 64'(TICK_NS);
    // Tick counter width: enough for the 100 s maximum.
    localparam int unsigned TIME_W = 30;
    // Shortest programmable delay or length, in ticks.
    localparam logic [TIME_W-1:0] MIN_TICKS = 30'h0000001;
    // Largest tick count as a sized value.
    localparam logic [TIME_W-1:0] MAX_TICKS_W = 30'(MAX_TICKS);
    // Trigger offset width: sign plus magnitude range.
    localparam int unsigned OFS_W = 31;
    // Reset values of the settings.
    localparam logic POL_RESET = 1'b0;
    localparam logic COMP_RESET = 1'b0;
    localparam logic [OFS_W-1:0] OFS_RESET = 31'h00000000;
    localparam logic [TIME_W-1:0] DELAY_RESET = 30'h0000001;
    localparam logic [TIME_W-1:0] LENGTH_RESET = 30'h0000001;

    // Trigger sources.
    typedef enum logic [1:0]
    {
        GST_SRC_FREE  = 2'b00,
        GST_SRC_VIDEO = 2'b01,
        GST_SRC_EXT   = 2'b10,
        GST_SRC_IFP   = 2'b11
    } gst_src_e;

    // Gate sequencer states.
    typedef enum logic [1:0]
    {
        GST_ST_IDLE  = 2'b00,
        GST_ST_DELAY = 2'b01,
        GST_ST_RUN   = 2'b10
    } gst_state_e;
endpackage

// ==== logic/gst_tick_gen.sv ====
// Time base generator: one-cycle pulse every DIVIDE reference cycles, 31 by default (124 ns).
// Assumes the reference clock of the package and a synchronous active-low reset.
`timescale 1ns/1ps
module gst_tick_gen
    import gst_pkg::*;
#(
    parameter int unsigned DIVIDE = TICK_CYCLES
)
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Tick pulse.
    output logic o_tick
);
    // Cycle counter within one tick period.
    logic [7:0] count;

    // Count reference cycles and pulse on wrap.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            count <= 8'h00;
            o_tick <= 1'b0;
        end
        else if (count == 8'(DIVIDE - 1))
        begin
            count <= 8'h00;
            o_tick <= 1'b1;
        end
        else
        begin
            count <= count + 8'h01;
            o_tick <= 1'b0;
        end
    end
endmodule

// ==== logic/gst_sync.sv ====
// Two-flop synchroniser for a single asynchronous level.
// Assumes the input comes from outside the reference clock domain.
`timescale 1ns/1ps
module gst_sync
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Asynchronous level in, synchronised level out.
    input wire logic i_async,
    output logic o_sync
);
    // First stage; read only by the second stage.
    logic meta;

    // Two flip-flops in series; the first one is never read elsewhere.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end
        else
        begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule

// ==== logic/gst_gate_ctrl.sv ====
// Gated sweep and trigger control: decides when the sweep starts, pauses and resumes.
// Assumes settings come from the instrument controller on the same clock and that
// the rear control input and the IF power detector output are asynchronous levels.
//
// Overview of operation
// RULE_01 - Sweep starts on selected trigger edge.
// RULE_02 - Polarity applies except free run; gates too.
// RULE_03 - Polarity defaults to rising edge.
// RULE_04 - Gate paces sweep from external or IF power.
// RULE_05 - Edge gating uses gate length; level follows signal.
// RULE_06 - Gating forces IF power source if needed.
// RULE_07 - Indicator asserted while gating enabled.
// RULE_08 - Gate configuration forces zero span, restores span.
// RULE_09 - Gate length ignored and locked in level mode.
// RULE_10 - Level gating halts low, resumes after delay.
// RULE_11 - Edge gating: delay, then sweep gate length.
// RULE_12 - Gate polarity change sets trigger polarity.
// RULE_13 - Gate delay programmable 125 ns to 100 s; the code clamps to 1 to 800000000 ticks of 124 ns, 124 ns to 99.2 s.
// RULE_14 - Gate delay change updates trigger offset.
// RULE_15 - Gate length programmable 125 ns to 100 s; the code clamps to 1 to 800000000 ticks of 124 ns, 124 ns to 99.2 s.
// RULE_16 - Sweep time in gate configuration is temporary.
// RULE_17 - Group delay compensation enable, default off.
// RULE_18 - Gating works in zero span and sweeps.
// RULE_19 - Trigger offset in 125 ns steps, default zero; the code steps the offset in 124 ns ticks.
// RULE_20 - Delay and length counted in 125 ns ticks; the code's tick is 31 reference cycles, 124 ns.
`timescale 1ns/1ps
module gst_gate_ctrl
    import gst_pkg::*;
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Asynchronous signal inputs.
    input wire logic i_rear_control_input,
    input wire logic i_ifp_detect,
    // Video trigger event from the same clock domain.
    input wire logic i_video_trig,
    // Trigger source selection and write strobe.
    input wire gst_pkg::gst_src_e i_src,
    input wire logic i_src_we,
    // Trigger polarity write: 1 selects falling edge.
    input wire logic i_trig_pol_neg,
    input wire logic i_trig_pol_we,
    // Gate polarity write: 1 selects negative.
    input wire logic i_gate_pol_neg,
    input wire logic i_gate_pol_we,
    // Gating enable and mode: mode 1 selects edge gating.
    input wire logic i_gate_en,
    input wire logic i_gate_edge_mode,
    // Gate delay and gate length in 124 ns ticks with write strobes.
    input wire logic [gst_pkg::TIME_W-1:0] i_gate_delay,
    input wire logic i_gate_delay_we,
    input wire logic [gst_pkg::TIME_W-1:0] i_gate_length,
    input wire logic i_gate_length_we,
    // Trigger offset in signed 124 ns ticks with write strobe.
    input wire logic [gst_pkg::OFS_W-1:0] i_trig_offset,
    input wire logic i_trig_offset_we,
    // Gate configuration menu entry and exit, frequency span state.
    input wire logic i_gate_cfg_enter,
    input wire logic i_gate_cfg_exit,
    input wire logic i_span_is_freq,
    // Sweep time setting and write strobe.
    input wire logic [31:0] i_sweep_duration_setting,
    input wire logic i_sweep_duration_we,
    // Group delay compensation enable and write strobe.
    input wire logic i_delay_comp,
    input wire logic i_delay_comp_we,
    // Sweep run request from the sweep engine.
    input wire logic i_sweep_armed,
    // Sweep control outputs.
    output logic o_sweep_start,
    output logic o_sweep_run,
    // Current settings and indicators.
    output gst_pkg::gst_src_e o_src,
    output logic o_trig_pol_neg,
    output logic o_gating_indicator,
    output logic o_zero_span,
    output logic o_restore_freq_span,
    output logic [31:0] o_sweep_duration,
    output logic [gst_pkg::TIME_W-1:0] o_holdoff_marker_line,
    output logic [gst_pkg::TIME_W-1:0] o_duration_marker_line,
    output logic [gst_pkg::OFS_W-1:0] o_trig_offset,
    output logic o_delay_comp
);
    // Synchronised gate/trigger levels.
    logic ext_sync;
    logic ifp_sync;
    // Time base pulse, one every 31 reference cycles (124 ns).
    logic tick;
    // Selected input after polarity, and its previous value.
    logic gate_level;
    logic gate_prev;
    // Gate sequencer state and tick counter.
    gst_state_e state;
    logic [TIME_W-1:0] count;
    // Gate configuration menu state and saved settings.
    logic in_cfg;
    logic saved_freq;
    logic [31:0] saved_sweep;
    // Trigger offset delay counter for non-gated triggering.
    logic trig_wait;
    logic [OFS_W-1:0] trig_count;

    // Clamp a tick count into the legal 1 to 800000000 tick range (124 ns to 99.2 s).
    function automatic logic [TIME_W-1:0] clamp_ticks(input logic [TIME_W-1:0] value);
        if (value < MIN_TICKS)
            return MIN_TICKS;
        if (value > MAX_TICKS_W)
            return MAX_TICKS_W;
        return value;
    endfunction

    // Rear control line synchroniser.
    gst_sync u_sync_ext
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_rear_control_input),
        .o_sync(ext_sync)
    );

    // IF power detector synchroniser.
    gst_sync u_sync_ifp
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_ifp_detect),
        .o_sync(ifp_sync)
    );

    // Time base that both counters run on.
    gst_tick_gen u_tick
    (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .o_tick(tick)
    );

    // Select the gate/trigger input and apply the one shared polarity.
    always_comb
    begin
        case (o_src)
            GST_SRC_EXT: gate_level = ext_sync ^ o_trig_pol_neg; // RULE_04
            GST_SRC_IFP: gate_level = ifp_sync ^ o_trig_pol_neg; // RULE_02
            GST_SRC_VIDEO: gate_level = i_video_trig ^ o_trig_pol_neg;
            default: gate_level = 1'b0;
        endcase
    end

    // Trigger source; enabling gating from an unsuitable source forces IF power.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_src <= GST_SRC_FREE;
        else if (i_gate_en && (o_src != GST_SRC_EXT) && (o_src != GST_SRC_IFP))
            o_src <= GST_SRC_IFP; // RULE_06
        // Gating keeps the source on external or IF power.
        else if (i_src_we && !(i_gate_en && (i_src != GST_SRC_EXT) && (i_src != GST_SRC_IFP)))
            o_src <= i_src;
    end

    // One polarity setting serves both trigger edge and gate sense.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_trig_pol_neg <= POL_RESET; // RULE_03
        else if (i_gate_pol_we)
            o_trig_pol_neg <= i_gate_pol_neg; // RULE_12
        else if (i_trig_pol_we)
            o_trig_pol_neg <= i_trig_pol_neg; // RULE_01
    end

    // Gate delay and trigger offset share one register path.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_holdoff_marker_line <= DELAY_RESET;
            o_trig_offset <= OFS_RESET; // RULE_19
        end
        else if (i_gate_delay_we)
        begin
            o_holdoff_marker_line <= clamp_ticks(i_gate_delay); // RULE_13
            // The shared input makes the delay also the trigger offset.
            o_trig_offset <= {1'b0, clamp_ticks(i_gate_delay)}; // RULE_14
        end
        else if (i_trig_offset_we)
            o_trig_offset <= i_trig_offset; // RULE_19
    end

    // Gate length; locked while level gating is selected.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_duration_marker_line <= LENGTH_RESET;
        else if (i_gate_length_we && i_gate_edge_mode) // RULE_09
            o_duration_marker_line <= clamp_ticks(i_gate_length); // RULE_15
    end

    // Group delay compensation enable.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            o_delay_comp <= COMP_RESET; // RULE_17
        else if (i_delay_comp_we)
            o_delay_comp <= i_delay_comp;
    end

    // Gate configuration: zero span on entry, restore span and sweep time on exit.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            in_cfg <= 1'b0;
            saved_freq <= 1'b0;
            saved_sweep <= 32'h00000000;
            o_zero_span <= 1'b0;
            o_restore_freq_span <= 1'b0;
            o_sweep_duration <= 32'h00000000;
        end
        else
        begin
            o_restore_freq_span <= 1'b0;
            if (i_gate_cfg_enter && !in_cfg)
            begin
                in_cfg <= 1'b1;
                saved_freq <= i_span_is_freq;
                saved_sweep <= o_sweep_duration; // RULE_16
                o_zero_span <= 1'b1; // RULE_08
            end
            else if (i_gate_cfg_exit && in_cfg)
            begin
                in_cfg <= 1'b0;
                o_zero_span <= 1'b0;
                o_restore_freq_span <= saved_freq; // RULE_08
                o_sweep_duration <= saved_sweep; // RULE_16
            end
            else if (i_sweep_duration_we)
                o_sweep_duration <= i_sweep_duration_setting;
        end
    end

    // Gate sequencer: pause, wait the delay, then run by level or for the length.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            state <= GST_ST_IDLE;
            count <= '0;
            gate_prev <= 1'b0;
        end
        else
        begin
            gate_prev <= gate_level;
            if (!i_gate_en)
            begin
                state <= GST_ST_IDLE;
                count <= '0;
            end
            else
            begin
                case (state)
                    GST_ST_IDLE:
                    begin
                        // Level mode reacts to the active level, edge mode to its leading edge.
                        if (i_gate_edge_mode ? (gate_level && !gate_prev) : gate_level) // RULE_11
                        begin
                            state <= GST_ST_DELAY;
                            count <= '0;
                        end
                    end
                    GST_ST_DELAY:
                    begin
                        if (!i_gate_edge_mode && !gate_level)
                            state <= GST_ST_IDLE; // RULE_10
                        else if (tick && (count + 30'h0000001 >= o_holdoff_marker_line)) // RULE_20
                        begin
                            state <= GST_ST_RUN;
                            count <= '0;
                        end
                        else if (tick)
                            count <= count + 30'h0000001;
                    end
                    GST_ST_RUN:
                    begin
                        // Level mode follows the applied gate; edge mode counts the length.
                        if (!i_gate_edge_mode)
                            state <= gate_level ? GST_ST_RUN : GST_ST_IDLE; // RULE_05
                        else if (tick && (count + 30'h0000001 >= o_duration_marker_line)) // RULE_05
                        begin
                            state <= GST_ST_IDLE;
                            count <= '0;
                        end
                        else if (tick)
                            count <= count + 30'h0000001;
                    end
                    default:
                        state <= GST_ST_IDLE;
                endcase
            end
        end
    end

    // Non-gated trigger: wait the positive offset after the edge, then start.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            trig_wait <= 1'b0;
            trig_count <= '0;
            o_sweep_start <= 1'b0;
        end
        else
        begin
            o_sweep_start <= 1'b0;
            if (i_gate_en || !i_sweep_armed)
                trig_wait <= 1'b0;
            // Free run ignores polarity and starts immediately.
            else if (o_src == GST_SRC_FREE)
                o_sweep_start <= 1'b1; // RULE_02
            else if (!trig_wait && gate_level && !gate_prev) // RULE_01
            begin
                // Negative offsets act as zero here; pretrigger is handled by capture memory.
                if (o_trig_offset[OFS_W-1] || o_trig_offset == '0)
                    o_sweep_start <= 1'b1;
                else
                begin
                    trig_wait <= 1'b1;
                    trig_count <= '0;
                end
            end
            else if (trig_wait && tick)
            begin
                if (trig_count + 31'h00000001 >= o_trig_offset)
                begin
                    trig_wait <= 1'b0;
                    o_sweep_start <= 1'b1;
                end
                else
                    trig_count <= trig_count + 31'h00000001;
            end
        end
    end

    // Sweep run enable and gating indicator, registered.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            o_sweep_run <= 1'b0;
            o_gating_indicator <= 1'b0;
        end
        else
        begin
            // Gating applies regardless of span.
            o_sweep_run <= i_gate_en ? (state == GST_ST_RUN) : i_sweep_armed; // RULE_18
            o_gating_indicator <= i_gate_en; // RULE_07
        end
    end
endmodule

// ==== tb/gst_gate_src.sv ====
// Model of the external gate source: rear control line and IF power detector.
// Assumes the bench sets the requested level; lines change off the clock edges.
`timescale 1ns/1ps
module gst_gate_src
(
    // Requests from the bench.
    input wire logic i_level,
    input wire logic i_use_ifp,
    input wire logic i_slow,
    // Lines into the block.
    output logic o_rear,
    output logic o_ifp
);
    // Activity on the unused line, so a block listening to it is caught.
    logic noise = 1'b0;
    always #7.3 noise = !noise;
    // The chosen line follows the request, promptly or slowly, at an unrelated phase.
    always @(i_level or i_use_ifp or noise)
    begin
        o_rear <= #(i_slow ? 9.1 : 1.7) (i_use_ifp ? noise : i_level);
        o_ifp <= #(i_slow ? 9.1 : 1.7) (i_use_ifp ? i_level : noise);
    end
endmodule

// ==== tb/gst_gate_ctrl_monitor.sv ====
// Assertions on the ports of the gate control block.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module gst_gate_ctrl_monitor
    import gst_pkg::*;
(
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Watched inputs.
    input wire logic i_rear_control_input,
    input wire logic i_src_we,
    input wire logic i_gate_en,
    input wire logic i_gate_edge_mode,
    input wire logic i_trig_pol_neg,
    input wire logic i_trig_pol_we,
    input wire logic i_gate_pol_neg,
    input wire logic i_gate_pol_we,
    input wire logic [gst_pkg::TIME_W-1:0] i_gate_delay,
    input wire logic i_gate_delay_we,
    input wire logic i_gate_length_we,
    input wire logic i_trig_offset_we,
    input wire logic i_gate_cfg_enter,
    input wire logic i_gate_cfg_exit,
    // Watched outputs.
    input wire logic o_sweep_run,
    input wire gst_pkg::gst_src_e o_src,
    input wire logic o_trig_pol_neg,
    input wire logic o_gating_indicator,
    input wire logic o_zero_span,
    input wire logic o_restore_freq_span,
    input wire logic [gst_pkg::TIME_W-1:0] o_holdoff_marker_line,
    input wire logic [gst_pkg::TIME_W-1:0] o_duration_marker_line,
    input wire logic [gst_pkg::OFS_W-1:0] o_trig_offset,
    input wire logic o_delay_comp
);
    import gst_pkg::*;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Level gating, positive sense, external line held inactive.
    sequence s_level_low;
        o_gating_indicator && !i_gate_edge_mode && !o_trig_pol_neg && o_src == GST_SRC_EXT && !i_rear_control_input;
    endsequence
    a_reset_values: assert property ($rose(i_rst_n) |-> o_src == GST_SRC_FREE && o_trig_pol_neg == POL_RESET &&
        o_delay_comp == COMP_RESET && o_trig_offset == OFS_RESET && o_holdoff_marker_line == DELAY_RESET)
        else $error("settings not at reset values");
    a_gate_wins_pol: assert property (i_gate_pol_we |=> o_trig_pol_neg == $past(i_gate_pol_neg))
        else $error("gate polarity write not applied to trigger polarity");
    a_trig_pol_write: assert property (i_trig_pol_we && !i_gate_pol_we |=> o_trig_pol_neg == $past(i_trig_pol_neg))
        else $error("trigger polarity write lost");
    a_delay_sets_offset: assert property (i_gate_delay_we && !i_trig_offset_we && i_gate_delay != 0 &&
        i_gate_delay <= MAX_TICKS_W |=> o_holdoff_marker_line == $past(i_gate_delay) &&
        o_trig_offset == OFS_W'($past(i_gate_delay))) else $error("gate delay not copied to offset");
    a_length_locked: assert property (i_gate_length_we && !i_gate_edge_mode |=> $stable(o_duration_marker_line))
        else $error("gate length changed in level mode");
    a_src_forced_ifp: assert property (i_gate_en && !o_src[1] && !i_src_we |=> o_src == GST_SRC_IFP)
        else $error("gating did not force IF power source");
    a_gate_indicator: assert property (i_gate_en |=> o_gating_indicator)
        else $error("gating indicator missing");
    a_cfg_zero_span: assert property (i_gate_cfg_enter && !o_zero_span |=> o_zero_span)
        else $error("zero span not entered");
    a_restore_pulse: assert property (o_restore_freq_span |-> ($past(i_gate_cfg_exit) && !o_zero_span) ##1
        !o_restore_freq_span) else $error("span restore pulse wrong");
    a_level_halts: assert property (s_level_low [*6] |-> !o_sweep_run)
        else $error("sweep runs while level gate inactive");
endmodule
bind gst_gate_ctrl gst_gate_ctrl_monitor u_mon (.*);

// ==== tb/gst_gate_ctrl_tb.sv ====
// Self-checking bench for the gated sweep trigger control block.
// Assumes the partner model feeds the gate lines; inputs change at falling edges.
`timescale 1ns/1ps
module gst_gate_ctrl_tb;
    import gst_pkg::*;
    // Block ports.
    logic i_ref_clk, i_rst_n, i_rear_control_input, i_ifp_detect, i_video_trig, i_src_we;
    gst_src_e i_src, o_src;
    logic i_trig_pol_neg, i_trig_pol_we, i_gate_pol_neg, i_gate_pol_we, i_gate_en, i_gate_edge_mode;
    logic [TIME_W-1:0] i_gate_delay, i_gate_length, o_holdoff_marker_line, o_duration_marker_line;
    logic i_gate_delay_we, i_gate_length_we, i_trig_offset_we, i_gate_cfg_enter, i_gate_cfg_exit;
    logic [OFS_W-1:0] i_trig_offset, o_trig_offset;
    logic [31:0] i_sweep_duration_setting, o_sweep_duration;
    logic i_span_is_freq, i_sweep_duration_we, i_delay_comp, i_delay_comp_we, i_sweep_armed;
    logic o_sweep_start, o_sweep_run, o_trig_pol_neg, o_gating_indicator, o_zero_span;
    logic o_restore_freq_span, o_delay_comp;
    // Partner requests, strobe selectors and counters.
    logic gate_level, gate_ifp, gate_slow;
    localparam int SRC = 0, TPOL = 1, GPOL = 2, DLY = 3, LEN = 4, OFS = 5, DUR = 6, COMP = 7, ENTER = 8, EXIT = 9;
    int failures, n_compared, runs, starts;

    gst_gate_ctrl DUT (.*);
    gst_gate_src u_src (.i_level(gate_level), .i_use_ifp(gate_ifp), .i_slow(gate_slow),
        .o_rear(i_rear_control_input), .o_ifp(i_ifp_detect));

    // Free-running reference clock.
    initial
    begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    // Compares one value and reports a mismatch at once.
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One setting write: data and one strobe stand for one rising edge.
    task automatic wr(input int sel, input logic [31:0] v);
        @(negedge i_ref_clk);
        i_src = gst_src_e'(v[1:0]);
        {i_trig_pol_neg, i_gate_pol_neg, i_delay_comp} = {3{v[0]}};
        {i_gate_delay, i_gate_length} = {2{v[29:0]}};
        i_trig_offset = v[30:0];
        i_sweep_duration_setting = v;
        {i_gate_cfg_exit, i_gate_cfg_enter, i_delay_comp_we, i_sweep_duration_we, i_trig_offset_we, i_gate_length_we,
            i_gate_delay_we, i_gate_pol_we, i_trig_pol_we, i_src_we} = 10'h001 << sel;
        @(negedge i_ref_clk);
        {i_gate_cfg_exit, i_gate_cfg_enter, i_delay_comp_we, i_sweep_duration_we, i_trig_offset_we, i_gate_length_we,
            i_gate_delay_we, i_gate_pol_we, i_trig_pol_we, i_src_we} = 10'h000;
    endtask

    // Counts cycles of sweep run and sweep start pulses over n cycles.
    task automatic count(input int n);
        runs = 0;
        starts = 0;
        repeat (n)
        begin
            @(negedge i_ref_clk);
            runs += (o_sweep_run === 1'b1);
            starts += (o_sweep_start === 1'b1);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Cuts a hang short; the sequence needs under two thousand cycles.
    initial
    begin
        repeat (50000) @(posedge i_ref_clk);
        failures++;
        stop_test();
    end

    // Main sequence of scenarios.
    initial
    begin
        failures = 0;
        n_compared = 0;
        i_rst_n = 1'b0;
        i_src = GST_SRC_FREE;
        {i_video_trig, i_gate_en, i_gate_edge_mode, i_span_is_freq, i_sweep_armed} = 5'h00;
        {gate_level, gate_ifp, gate_slow, i_trig_pol_neg, i_gate_pol_neg, i_delay_comp} = 6'h00;
        {i_gate_delay, i_gate_length, i_trig_offset, i_sweep_duration_setting} = '0;
        {i_gate_cfg_exit, i_gate_cfg_enter, i_delay_comp_we, i_sweep_duration_we, i_trig_offset_we, i_gate_length_we,
            i_gate_delay_we, i_gate_pol_we, i_trig_pol_we, i_src_we} = 10'h000;
        repeat (20) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        @(negedge i_ref_clk);
        check("pol", o_trig_pol_neg, POL_RESET);
        check("offset", o_trig_offset, OFS_RESET);
        check("comp", o_delay_comp, COMP_RESET);
        check("length", o_duration_marker_line, LENGTH_RESET);
        wr(TPOL, 1);
        check("tpol", o_trig_pol_neg, 1'b1);
        wr(GPOL, 0);
        check("gpol", o_trig_pol_neg, 1'b0);
        wr(DLY, 0);
        check("delay min", o_holdoff_marker_line, MIN_TICKS);
        wr(DLY, 32'h3FFFFFFF);
        check("delay max", o_holdoff_marker_line, MAX_TICKS_W);
        wr(OFS, 32'h7FFFFFFD);
        check("offset neg", o_trig_offset, 31'h7FFFFFFD);
        wr(DLY, 2);
        check("offset", o_trig_offset, 31'h00000002);
        wr(LEN, 5);
        check("length lvl", o_duration_marker_line, LENGTH_RESET);
        i_gate_edge_mode = 1'b1;
        wr(LEN, 3);
        check("length", o_duration_marker_line, 30'h0000003);
        wr(COMP, 1);
        check("comp", o_delay_comp, 1'b1);
        wr(DUR, 100);
        i_span_is_freq = 1'b1;
        wr(ENTER, 0);
        check("zero span", o_zero_span, 1'b1);
        wr(DUR, 5);
        check("dur tmp", o_sweep_duration, 32'h00000005);
        wr(EXIT, 0);
        check("restore", o_restore_freq_span, 1'b1);
        check("dur back", o_sweep_duration, 32'h00000064);
        i_gate_en = 1'b1;
        wr(SRC, 0);
        check("src forced", o_src, GST_SRC_IFP);
        check("indicator", o_gating_indicator, 1'b1);
        wr(SRC, 2);
        check("src ext", o_src, GST_SRC_EXT);
        i_gate_edge_mode = 1'b0;
        count(10);
        gate_level = 1'b1;
        count(30);
        check("lvl held", runs, 0);
        count(70);
        check("lvl run", o_sweep_run, 1'b1);
        gate_level = 1'b0;
        count(8);
        check("lvl halt", o_sweep_run, 1'b0);
        wr(SRC, 3);
        {gate_ifp, gate_slow, i_gate_edge_mode} = 3'h7;
        count(10);
        gate_level = 1'b1;
        count(10);
        gate_level = 1'b0;
        count(290);
        check("edge len", runs, 3 * TICK_CYCLES);
        {i_gate_en, gate_ifp, gate_slow} = 3'h0;
        wr(SRC, 2);
        wr(OFS, 0);
        i_sweep_armed = 1'b1;
        count(5);
        gate_level = 1'b1;
        count(20);
        check("rise start", starts, 1);
        wr(TPOL, 1);
        gate_level = 1'b0;
        count(20);
        check("fall start", starts, 1);
        gate_level = 1'b1;
        count(20);
        check("rise ignored", starts, 0);
        stop_test();
    end
endmodule
